// ==== verilog/flash_guard_defines.vh ====
// Opcodes, protection range and timing constants of the erase and write guard
`ifndef FLASH_GUARD_DEFINES_VH
`define FLASH_GUARD_DEFINES_VH

`define OP_BLOCK_ERASE_4K   8'h20
`define OP_BLOCK_ERASE_32A  8'h52
`define OP_BLOCK_ERASE_32B  8'hD8
`define OP_CHIP_ERASE_A     8'h60
`define OP_CHIP_ERASE_B     8'h62
`define OP_CHIP_ERASE_C     8'hC7
`define OP_WRITE_ENABLE     8'h06
`define OP_WRITE_DISABLE    8'h04
`define OP_WRITE_STATUS     8'h01

`define ADDR_WIDTH          24
`define PROTECT_TOP         24'h01FFFF
`define BLOCK4K_LOW_BITS    12
`define BLOCK32K_LOW_BITS   15

// Status byte written by the write-status command
`define STAT_PROTECT_POS    2
`define STAT_LOCK_POS       7
`define PROTECT_FACTORY     1'b0

// Erase times in microseconds, and the clock rate in MHz
`define CLK_MHZ             100
`define BLOCK_ERASE_US      1000
`define CHIP_ERASE_US       8000
`define BLOCK_ERASE_CYCLES  (`BLOCK_ERASE_US * `CLK_MHZ)
`define CHIP_ERASE_CYCLES   (`CHIP_ERASE_US * `CLK_MHZ)

`endif

// ==== verilog/spi_byte_shifter.v ====
// Serial-in byte shifter with pin synchronisers and frame edge detection
`timescale 1ns/1ps
module spi_byte_shifter (
    input  wire       ref_clk,
    input  wire       srst,
    input  wire       chipSelectN,
    input  wire       serialClk,
    input  wire       serialIn,
    output reg        frameStart,
    output reg        frameEnd,
    output reg        byteValid,
    output reg  [7:0] byteData,
    output reg        bitAligned
);
    reg [1:0] csSync_reg;
    reg [1:0] sckSync_reg;
    reg [1:0] sdiSync_reg;
    reg       csLast_reg;
    reg       sckLast_reg;
    reg [2:0] bitCount_reg;
    reg [6:0] shift_reg;
    wire      csLow   = ~csSync_reg[1];
    wire      sckRise = sckSync_reg[1] & ~sckLast_reg;

    ////////////////////////////////////////////////////////////////////////////
    always @(posedge ref_clk) begin
        if (srst) begin
            csSync_reg   <= 2'h3;
            sckSync_reg  <= 2'h0;
            sdiSync_reg  <= 2'h0;
            csLast_reg   <= 1'b1;
            sckLast_reg  <= 1'b0;
            bitCount_reg <= 3'h0;
            shift_reg    <= 7'h00;
            frameStart   <= 1'b0;
            frameEnd     <= 1'b0;
            byteValid    <= 1'b0;
            byteData     <= 8'h00;
            bitAligned   <= 1'b1;
        end else begin
            csSync_reg  <= {csSync_reg[0], chipSelectN};
            sckSync_reg <= {sckSync_reg[0], serialClk};
            sdiSync_reg <= {sdiSync_reg[0], serialIn};
            csLast_reg  <= csSync_reg[1];
            sckLast_reg <= sckSync_reg[1];
            frameStart  <= csLast_reg & csLow;
            frameEnd    <= ~csLast_reg & ~csLow;
            byteValid   <= 1'b0;
            if (csLast_reg & csLow) begin
                bitCount_reg <= 3'h0;
                bitAligned   <= 1'b1;
            end else if (csLow && sckRise) begin
                // Most significant bit arrives first; see R23
                shift_reg    <= {shift_reg[5:0], sdiSync_reg[1]};
                bitCount_reg <= bitCount_reg + 3'h1;
                bitAligned   <= (bitCount_reg == 3'h7);
                if (bitCount_reg == 3'h7) begin
                    byteValid <= 1'b1;
                    byteData  <= {shift_reg, sdiSync_reg[1]};
                end
            end
        end
    end
endmodule

// ==== verilog/flash_erase_guard.v ====
// Command decoder and erase sequencer guarding the array with the write latch
//
// Functional notes
// R1: Opcode 20h erases 4 KB block; 52h or D8h erases 32 KB block.
// R2: Block erase runs only with the write enable latch already set.
// R3: Erase opcode plus three address bytes; extra bytes ignored; starts at deselect.
// R4: Address bits below block size are ignored when choosing the block.
// R5: Incomplete address or off-byte deselect aborts the block erase.
// R6: Protected array: block erase skipped, back to idle at deselect.
// R7: Aborted or protected block erase clears the write enable latch.
// R8: Busy during a running erase; latch cleared before the erase ends.
// R9: Host should poll busy rather than wait the full erase time.
// R10: Each byte is verified after erase; failure sets the error flag.
// R11: Opcodes 60h, 62h and C7h all mean chip erase.
// R12: Chip erase takes no address; erases whole array at deselect.
// R13: Bad opcode framing or protection skips chip erase; some cases clear latch.
// R14: Erase and status write refused unless the latch was set beforehand.
// R15: Opcode 06h sets the latch at deselect; trailing bytes ignored.
// R16: Opcode 04h clears the latch at deselect; trailing bytes ignored.
// R17: Bad framing of 06h or 04h leaves the latch unchanged.
// R18: Protect bit set protects 00000h to 01FFFFh against erase.
// R19: Protect bit changes only through the write-status command.
// R20: Protect bit is nonvolatile and starts at the factory value zero. The code holds it in a flop that srst resets to zero.
// R21: Protect bit updates may be locked by write-protect pin and lock bit.
// R22: Lock holds when write-protect pin is low and lock bit is one.
// R23: Bytes are shifted in MSB first on rising serial clock edges.
`timescale 1ns/1ps
`include "flash_guard_defines.vh"
module flash_erase_guard #(
    parameter BLOCK_ERASE_CYCLES = `BLOCK_ERASE_CYCLES,
    parameter CHIP_ERASE_CYCLES  = `CHIP_ERASE_CYCLES
) (
    input  wire                   ref_clk,
    input  wire                   srst,
    input  wire                   chipSelectN,
    input  wire                   serialClk,
    input  wire                   serialIn,
    input  wire                   writeProtectN,
    input  wire                   verifyFail,
    output reg                    writeEnableLatch,
    output reg                    arrayProtectBit,
    output reg                    protectLockBit,
    output reg                    eraseProgramErrorFlag,
    output reg                    busy,
    output reg                    eraseStart,
    output reg                    eraseChip,
    output reg  [`ADDR_WIDTH-1:0] eraseAddr,
    output reg                    eraseDone
);
    localparam ST_IDLE   = 2'h0;
    localparam ST_ERASE  = 2'h1;
    localparam ST_VERIFY = 2'h2;

    localparam CMD_NONE  = 3'h0;
    localparam CMD_BLK4  = 3'h1;
    localparam CMD_BLK32 = 3'h2;
    localparam CMD_CHIP  = 3'h3;
    localparam CMD_WREN  = 3'h4;
    localparam CMD_WRDI  = 3'h5;
    localparam CMD_WRSR  = 3'h6;

    wire       frameStart;
    wire       frameEnd;
    wire       byteValid;
    wire [7:0] byteData;
    wire       bitAligned;

    reg [1:0]  state_reg;
    reg [2:0]  cmd_reg;
    reg [2:0]  byteCount_reg;
    reg [23:0] addr_reg;
    reg [7:0]  statusByte_reg;
    reg [31:0] timer_reg;

    // Decoding shared by the opcode capture and nothing else would be a wire,
    // but the function keeps opcode groups in one place.
    function [2:0] decodeOp;
        input [7:0] op;
        begin
            if (op == `OP_BLOCK_ERASE_4K)
                decodeOp = CMD_BLK4;                                   // see R1
            else if (op == `OP_BLOCK_ERASE_32A || op == `OP_BLOCK_ERASE_32B)
                decodeOp = CMD_BLK32;                                  // see R1
            else if (op == `OP_CHIP_ERASE_A || op == `OP_CHIP_ERASE_B ||
                     op == `OP_CHIP_ERASE_C)
                decodeOp = CMD_CHIP;                                   // see R11
            else if (op == `OP_WRITE_ENABLE)
                decodeOp = CMD_WREN;
            else if (op == `OP_WRITE_DISABLE)
                decodeOp = CMD_WRDI;
            else if (op == `OP_WRITE_STATUS)
                decodeOp = CMD_WRSR;
            else
                decodeOp = CMD_NONE;
        end
    endfunction

    spi_byte_shifter shifter (
        .ref_clk     (ref_clk),
        .srst        (srst),
        .chipSelectN (chipSelectN),
        .serialClk   (serialClk),
        .serialIn    (serialIn),
        .frameStart  (frameStart),
        .frameEnd    (frameEnd),
        .byteValid   (byteValid),
        .byteData    (byteData),
        .bitAligned  (bitAligned)
    );

    // Write-protect pin comes from outside the clock domain
    reg [1:0] wpSync_reg;
    always @(posedge ref_clk) begin
        if (srst)
            wpSync_reg <= 2'h3;
        else
            wpSync_reg <= {wpSync_reg[0], writeProtectN};
    end

    wire hwLocked  = ~wpSync_reg[1] & protectLockBit;                  // see R22
    wire addrFull  = (byteCount_reg >= 3'h4);
    wire opFull    = (byteCount_reg >= 3'h1);
    // Whole array lies inside the protected range, so any target is protected
    // Upper address bits wrap onto the array, so the compare would wrongly pass them
    wire regionProtected = arrayProtectBit;                            // see R18

    // Block base: low bits are forced to zero for the block size
    wire [23:0] blk4Base  = {addr_reg[23:`BLOCK4K_LOW_BITS],
                             {`BLOCK4K_LOW_BITS{1'b0}}};
    wire [23:0] blk32Base = {addr_reg[23:`BLOCK32K_LOW_BITS],
                             {`BLOCK32K_LOW_BITS{1'b0}}};

    ////////////////////////////////////////////////////////////////////////////
    // Frame capture: opcode, address and status byte
    always @(posedge ref_clk) begin
        if (srst) begin
            cmd_reg        <= CMD_NONE;
            byteCount_reg  <= 3'h0;
            addr_reg       <= 24'h000000;
            statusByte_reg <= 8'h00;
        end else if (frameStart) begin
            cmd_reg       <= CMD_NONE;
            byteCount_reg <= 3'h0;
        end else if (byteValid) begin
            if (byteCount_reg != 3'h7)
                byteCount_reg <= byteCount_reg + 3'h1;
            if (byteCount_reg == 3'h0)
                cmd_reg <= busy ? CMD_NONE : decodeOp(byteData);
            else if (byteCount_reg <= 3'h3)
                // Bytes past the third address byte are ignored; see R3
                addr_reg <= {addr_reg[15:0], byteData};
            if (byteCount_reg == 3'h1)
                statusByte_reg <= byteData;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Command completion at deselect, and the self-timed erase
    always @(posedge ref_clk) begin
        if (srst) begin
            state_reg             <= ST_IDLE;
            writeEnableLatch      <= 1'b0;
            // Nonvolatile bit modelled as a flop reset to its factory value; see R20
            arrayProtectBit       <= `PROTECT_FACTORY;
            protectLockBit        <= 1'b0;
            eraseProgramErrorFlag <= 1'b0;
            busy                  <= 1'b0;
            eraseStart            <= 1'b0;
            eraseChip             <= 1'b0;
            eraseAddr             <= 24'h000000;
            eraseDone             <= 1'b0;
            timer_reg             <= 32'h00000000;
        end else begin
            eraseStart <= 1'b0;
            eraseDone  <= 1'b0;
            case (state_reg)
            ST_IDLE: begin
                if (frameEnd) begin
                    case (cmd_reg)
                    CMD_BLK4, CMD_BLK32: begin
                        if (!addrFull || !bitAligned || regionProtected) begin
                            writeEnableLatch <= 1'b0;                 // see R5 R6 R7
                        end else if (writeEnableLatch) begin          // see R2 R14
                            state_reg  <= ST_ERASE;                   // see R3
                            busy       <= 1'b1;                       // see R8
                            eraseStart <= 1'b1;
                            eraseChip  <= 1'b0;
                            eraseAddr  <= (cmd_reg == CMD_BLK4) ? blk4Base
                                                                : blk32Base; // see R4
                            timer_reg  <= BLOCK_ERASE_CYCLES;
                        end
                    end
                    CMD_CHIP: begin
                        // Whole array is the target, so protection is the bit itself
                        if (!bitAligned || arrayProtectBit) begin
                            writeEnableLatch <= 1'b0;                 // see R13
                        end else if (writeEnableLatch && opFull) begin // see R14
                            state_reg  <= ST_ERASE;                   // see R12
                            busy       <= 1'b1;
                            eraseStart <= 1'b1;
                            eraseChip  <= 1'b1;
                            eraseAddr  <= 24'h000000;
                            timer_reg  <= CHIP_ERASE_CYCLES;
                        end
                    end
                    CMD_WREN: begin
                        if (bitAligned)
                            writeEnableLatch <= 1'b1;                 // see R15 R17
                    end
                    CMD_WRDI: begin
                        if (bitAligned)
                            writeEnableLatch <= 1'b0;                 // see R16 R17
                    end
                    CMD_WRSR: begin
                        // Only path that changes the protect bit; see R19 R21 R22
                        if (bitAligned && byteCount_reg >= 3'h2 &&
                                writeEnableLatch && !hwLocked) begin
                            arrayProtectBit  <= statusByte_reg[`STAT_PROTECT_POS];
                            protectLockBit   <= statusByte_reg[`STAT_LOCK_POS];
                            writeEnableLatch <= 1'b0;
                        end
                    end
                    default: begin
                    end
                    endcase
                end
            end
            ST_ERASE: begin
                // Latch drops early in the cycle so it is low well before done
                writeEnableLatch <= 1'b0;                             // see R8
                if (timer_reg <= 32'h00000001)
                    state_reg <= ST_VERIFY;
                else
                    timer_reg <= timer_reg - 32'h00000001;
            end
            ST_VERIFY: begin
                // Byte check result from the array decides the error flag
                eraseProgramErrorFlag <= verifyFail;                  // see R10
                busy      <= 1'b0;
                eraseDone <= 1'b1;
                state_reg <= ST_IDLE;
            end
            default: begin
                state_reg <= ST_IDLE;
            end
            endcase
        end
    end
endmodule

// ==== verif/flash_erase_guard_props.sv ====
// Concurrent checks on the erase guard's ports
`timescale 1ns/1ps
module flash_erase_guard_checker #(
    parameter BLOCK_ERASE_CYCLES = 20,
    parameter CHIP_ERASE_CYCLES  = 40
) (
    input wire logic        ref_clk,
    input wire logic        srst,
    input wire logic        writeProtectN,
    input wire logic        writeEnableLatch,
    input wire logic        arrayProtectBit,
    input wire logic        protectLockBit,
    input wire logic        eraseProgramErrorFlag,
    input wire logic        busy,
    input wire logic        eraseStart,
    input wire logic        eraseChip,
    input wire logic [23:0] eraseAddr,
    input wire logic        eraseDone
);
    logic [31:0] busyCount_reg;
    int          nomLen;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    // Counts busy cycles since the last start, so long erases need no unrolled repetition
    always @(posedge ref_clk) begin
        if (srst) begin
            busyCount_reg <= 32'h0;
        end else if (eraseStart) begin
            busyCount_reg <= 32'h1;
        end else if (busy) begin
            busyCount_reg <= busyCount_reg + 32'h1;
        end
    end
    assign nomLen = eraseChip ? CHIP_ERASE_CYCLES : BLOCK_ERASE_CYCLES;

    ////////////////////////////////////////////////////////////////////////////////
    a_start_needs_latch: assert property (eraseStart |-> $past(writeEnableLatch))
        else $error("erase started without the write latch");
    a_start_unprotected: assert property (eraseStart |-> !arrayProtectBit)
        else $error("erase started on a protected array");
    a_start_shows_busy: assert property (eraseStart |-> busy)
        else $error("busy not shown at erase start");
    a_latch_clears_run: assert property (eraseStart |-> ##[1:2] !writeEnableLatch)
        else $error("write latch not cleared during erase");
    a_block_base_aligned: assert property (eraseStart && !eraseChip |->
        eraseAddr[11:0] == 12'h000)
        else $error("block base has low address bits set");
    a_erase_run_length: assert property (eraseDone |->
        busyCount_reg >= nomLen - 1 && busyCount_reg <= nomLen + 2)
        else $error("erase time differs from the configured count");
    a_error_at_done: assert property ($rose(eraseProgramErrorFlag) |->
        eraseDone || $past(eraseDone))
        else $error("error flag set away from erase end");
    a_protect_hw_lock: assert property ($changed(arrayProtectBit) |->
        $past(writeProtectN, 8) || !$past(protectLockBit))
        else $error("protect bit changed while locked");
    a_latch_set_idle: assert property ($rose(writeEnableLatch) |-> !busy)
        else $error("write latch set during an erase");

    c_block_erase: cover property (eraseStart && !eraseChip);
    c_chip_erase: cover property (eraseStart && eraseChip);
    c_erase_error: cover property ($rose(eraseProgramErrorFlag));
endmodule

bind flash_erase_guard flash_erase_guard_checker #(
    .BLOCK_ERASE_CYCLES(BLOCK_ERASE_CYCLES),
    .CHIP_ERASE_CYCLES (CHIP_ERASE_CYCLES)
) i_flash_erase_guard_checker (.*);

// ==== verif/spi_host_model.sv ====
// Host serial controller model that frames opcode and address bits
`timescale 1ns/1ps
module spi_host_model (
    output logic chipSelectN,
    output logic serialClk,
    output logic serialIn
);
    initial begin
        chipSelectN = 1'b1;
        serialClk   = 1'b0;
        serialIn    = 1'b0;
    end

    // Bits are left-justified; a count off a multiple of eight makes a broken frame
    task automatic xfer(input logic [39:0] bits, input int n);
        int i;
        chipSelectN = 1'b0;
        for (i = 0; i < n; i++) begin
            serialIn = bits[39 - i];
            #62.5 serialClk = 1'b1;
            #62.5 serialClk = 1'b0;
        end
        #62.5 chipSelectN = 1'b1;
        // Released data line must not keep looking like valid data
        serialIn = ~serialIn;
        #200;
    endtask
endmodule

// ==== verif/tb_top.sv ====
// Self-checking bench for the erase and write guard
`timescale 1ns/1ps
`include "flash_guard_defines.vh"
module tb_top;
    logic                   ref_clk = 1'b0;
    logic                   srst = 1'b1;
    logic                   writeProtectN = 1'b1;
    logic                   verifyFail = 1'b0;
    wire                    chipSelectN, serialClk, serialIn;
    wire                    writeEnableLatch, arrayProtectBit, protectLockBit;
    wire                    eraseProgramErrorFlag, busy, eraseStart, eraseChip, eraseDone;
    wire [`ADDR_WIDTH-1:0]  eraseAddr;
    int                     n_fail = 0;
    int                     n_tests = 0;
    int                     nStarts = 0;
    int                     nDone = 0;
    logic [`ADDR_WIDTH-1:0] lastAddr;
    logic                   lastChip;
    logic [7:0]             ops [6] = '{`OP_BLOCK_ERASE_4K, `OP_BLOCK_ERASE_32A,
        `OP_BLOCK_ERASE_32B, `OP_CHIP_ERASE_A, `OP_CHIP_ERASE_B, `OP_CHIP_ERASE_C};
    logic [23:0]            bases [3] = '{24'h01B000, 24'h018000, 24'h018000};

    always #5 ref_clk = ~ref_clk;

    spi_host_model i_spi_host_model (.chipSelectN(chipSelectN), .serialClk(serialClk),
        .serialIn(serialIn));
    flash_erase_guard #(.BLOCK_ERASE_CYCLES(20), .CHIP_ERASE_CYCLES(40)) i_flash_erase_guard (
        .ref_clk(ref_clk), .srst(srst), .chipSelectN(chipSelectN), .serialClk(serialClk),
        .serialIn(serialIn), .writeProtectN(writeProtectN), .verifyFail(verifyFail),
        .writeEnableLatch(writeEnableLatch), .arrayProtectBit(arrayProtectBit),
        .protectLockBit(protectLockBit), .eraseProgramErrorFlag(eraseProgramErrorFlag),
        .busy(busy), .eraseStart(eraseStart), .eraseChip(eraseChip), .eraseAddr(eraseAddr),
        .eraseDone(eraseDone));

    always @(posedge ref_clk) begin
        if (eraseStart === 1'b1) begin
            nStarts++;
            lastAddr = eraseAddr;
            lastChip = eraseChip;
        end
        if (eraseDone === 1'b1) begin
            nDone++;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        if (n_fail == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One frame, then poll busy instead of sitting out the full erase time
    task automatic cmd(input logic [39:0] bits, input int n);
        int k;
        // Starting just off a falling edge keeps every link edge clear of ref_clk edges
        @(negedge ref_clk);
        #1;
        i_spi_host_model.xfer(bits, n);
        k = 0;
        while (busy !== 1'b0 && k < 200) begin
            @(negedge ref_clk);
            k++;
        end
        if (k == 200) begin
            check(1, 0);
            complete_run();
        end
        // Start and done pulses reach the counters one edge after they appear
        @(negedge ref_clk);
    endtask

    task automatic wren();
        cmd({`OP_WRITE_ENABLE, 32'h0}, 8);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        int i;
        repeat (2) @(negedge ref_clk);
        srst = 1'b0;
        @(negedge ref_clk);
        check(arrayProtectBit, 0);
        check(writeEnableLatch, 0);
        cmd({`OP_BLOCK_ERASE_4K, 24'h01BCDE, 8'h0}, 32);
        check(nStarts, 0);
        cmd({`OP_WRITE_ENABLE, 8'hFF, 24'h0}, 16);
        check(writeEnableLatch, 1);
        cmd({`OP_WRITE_DISABLE, 32'h0}, 12);
        check(writeEnableLatch, 1);
        cmd({`OP_WRITE_DISABLE, 8'hFF, 24'h0}, 16);
        check(writeEnableLatch, 0);
        cmd({`OP_WRITE_ENABLE, 32'h0}, 5);
        check(writeEnableLatch, 0);
        for (i = 0; i < 6; i++) begin
            @(negedge ref_clk);
            verifyFail = i[0];
            wren();
            cmd({ops[i], 24'h01BCDE, 8'h5A}, (i < 3) ? 40 : 16);
            check(nStarts, i + 1);
            check(lastChip, i >= 3);
            if (i < 3) begin
                check(lastAddr, bases[i]);
            end
            check(nDone, i + 1);
            check(eraseProgramErrorFlag, i[0]);
            check(writeEnableLatch, 0);
        end
        for (i = 0; i < 2; i++) begin
            wren();
            cmd({`OP_BLOCK_ERASE_32A, 24'h01BCDE, 8'h0}, i ? 35 : 24);
            check(nStarts, 6);
            check(writeEnableLatch, 0);
        end
        wren();
        cmd({`OP_CHIP_ERASE_B, 32'h0}, 11);
        check(nStarts, 6);
        check(writeEnableLatch, 0);
        wren();
        cmd({`OP_WRITE_STATUS, 8'h84, 24'h0}, 16);
        check(arrayProtectBit, 1);
        check(protectLockBit, 1);
        for (i = 0; i < 2; i++) begin
            wren();
            cmd({i ? `OP_CHIP_ERASE_C : `OP_BLOCK_ERASE_4K, 32'h0}, i ? 8 : 32);
            check(nStarts, 6);
            check(writeEnableLatch, 0);
        end
        @(negedge ref_clk);
        writeProtectN = 1'b0;
        wren();
        cmd({`OP_WRITE_STATUS, 32'h0}, 16);
        check(arrayProtectBit, 1);
        @(negedge ref_clk);
        writeProtectN = 1'b1;
        cmd({`OP_WRITE_DISABLE, 32'h0}, 8);
        cmd({`OP_WRITE_STATUS, 32'h0}, 16);
        check(arrayProtectBit, 1);
        wren();
        cmd({`OP_WRITE_STATUS, 32'h0}, 16);
        check(arrayProtectBit, 0);
        check(protectLockBit, 0);
        complete_run();
    end
endmodule
